//--- include/tpc_defs.vh
// Register map, field positions and fixed counts of the trigger and panel block
`ifndef TPC_DEFS_VH
`define TPC_DEFS_VH

// Register byte addresses
`define TPC_ADDR_SW_TRIG 16'h8108
`define TPC_ADDR_TRIG_SRC 16'h810C
`define TPC_ADDR_TRIG_OUT 16'h8110
`define TPC_ADDR_POST_CNT 16'h8114
`define TPC_ADDR_IO_DATA 16'h8118
`define TPC_ADDR_IO_CTRL 16'h811C
`define TPC_ADDR_GRP_EN 16'h8120

// Reset values
`define TPC_RST_TRIG_SRC 32'h00000000
`define TPC_RST_TRIG_OUT 32'h00000000
`define TPC_RST_POST_CNT 32'h00000000
`define TPC_RST_IO_DATA 16'h0000
`define TPC_RST_IO_CTRL 16'h0000
`define TPC_RST_GRP_EN 8'h00

// Writable bits; all others read as zero
`define TPC_MASK_TRIG_SRC 32'hC70000FF
`define TPC_MASK_TRIG_OUT 32'hC00000FF
`define TPC_MASK_IO_CTRL 16'hC2FF

// Trigger source and trigger out fields
`define TPC_BIT_SW_EN 31
`define TPC_BIT_EXT_EN 30
`define TPC_COINC_HI 26
`define TPC_COINC_LO 24

// Panel control fields
`define TPC_BIT_TEST_MODE 15
`define TPC_BIT_TEST_LEVEL 14
`define TPC_BIT_LATCH_EXT 9
`define TPC_MODE_HI 7
`define TPC_MODE_LO 6
`define TPC_DIR_HI 5
`define TPC_DIR_LO 2
`define TPC_BIT_HIZ 1
`define TPC_BIT_TTL 0

// Line usage modes
`define TPC_MODE_GPIO 2'h0
`define TPC_MODE_PROG 2'h1
`define TPC_MODE_PATTERN 2'h2

// Samples added by trigger processing, fixed for this logic version
`define TPC_FIXED_TRIG_DELAY 33'h0000000A

`endif

//--- src/tpc_coinc.v
// Local trigger decision with group coincidence level
`timescale 1ns/10ps
module tpc_coinc (
  // Group threshold state and enables
  input wire [7:0] grp_over_thr,
  input wire [7:0] grp_mask,
  input wire [2:0] coinc_level,
  // Decision
  output wire local_fire,
  output wire [3:0] active_count
);

  wire [7:0] active;

  function [3:0] count_ones;
    input [7:0] v;
    integer i;
    begin
      count_ones = 4'h0;
      for (i = 0; i < 8; i = i + 1) begin
        count_ones = count_ones + {3'h0, v[i]};
      end
    end
  endfunction

  assign active = grp_over_thr & grp_mask;
  assign active_count = count_ones(active);
  // Triggering group plus at least coinc_level others
  assign local_fire = (active_count > {1'b0, coinc_level});

endmodule // tpc_coinc

//--- src/tpc_sync.v
// Two flip-flop synchroniser for a bus of independent pin levels
`timescale 1ns/10ps
module tpc_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Asynchronous levels in, synchronised levels out
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // First stage feeds only the second stage
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // tpc_sync

//--- src/tpc_top.v
// Trigger source selection and front panel I/O control registers
`timescale 1ns/10ps
`include "tpc_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Any software trigger write makes one trigger
// - Software trigger accepted only with bit 31
// - External trigger input accepted only with bit 30
// - Low mask byte enables local trigger per group
// - Local trigger needs coincidence of coinc_level other groups
// - Trigger out mask byte forwards group triggers
// - Trigger out bits 30/31 forward external/software
// - Post samples equal setting plus fixed delay
// - Fixed trigger delay is a constant
// - Data register reads lines, writes output lines
// - Bit 15 selects static bit 14 trigger level
// - Bit 9 picks pattern capture moment
// - Mode field selects GPIO, programmed or pattern
// - In GPIO mode bits 5:2 set nibble direction
// - Bit 1 floats trigger and clock outputs
// - Bit 0 selects NIM or TTL levels
// - Only enabled groups store samples
// - All acquisition triggers ignored while run bit clear
module tpc_top (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Register port
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata_ff,
  output reg reg_rvalid_ff,
  // Acquisition state and group threshold flags
  input wire acq_run,
  input wire [7:0] grp_over_thr,
  // Front panel trigger input and output
  input wire external_trigger_input,
  output reg trigger_output_line_ff,
  output reg trigger_output_oe_ff,
  output reg clock_output_oe_ff,
  output reg level_ttl_sel_ff,
  // Front panel differential lines
  input wire [15:0] lvds_in,
  output reg [15:0] lvds_out_ff,
  output reg [15:0] lvds_oe_ff,
  // Acquisition side
  output reg acq_trigger_ff,
  output reg post_active_ff,
  output reg post_done_ff,
  output reg [31:0] post_count_setting_ff,
  output reg [7:0] store_group_ff,
  output reg [15:0] pattern_ff,
  output reg pattern_stb_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  reg [31:0] trig_src_ff;
  reg [31:0] trig_out_ff;
  reg [31:0] post_cnt_ff;
  reg [15:0] io_data_ff;
  reg [15:0] io_ctrl_ff;
  reg [7:0] grp_en_ff;
  reg ext_dly_ff;
  reg [32:0] post_left_ff;

  reg [31:0] nxt_rdata;
  reg [15:0] nxt_oe;
  reg nxt_trig_level;
  reg [32:0] nxt_post_left;
  reg nxt_post_active;
  reg nxt_post_done;

  wire ext_sync;
  wire [15:0] lvds_sync;
  wire local_fire;
  wire [3:0] active_count;
  wire sw_write;
  wire ext_rise;
  wire sw_trig;
  wire ext_trig;
  wire loc_trig;
  wire any_trig;
  wire fwd_trig;
  wire [1:0] io_mode;
  wire [32:0] post_total;
  wire [15:0] line_level;
  wire delayed_trig;
  wire capture_now;

  function [31:0] masked;
    input [31:0] value;
    input [31:0] keep;
    begin
      masked = value & keep;
    end
  endfunction

  function hit;
    input [15:0] addr;
    input [15:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  tpc_sync #(
    .WIDTH(1)
  ) u_ext_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(external_trigger_input),
    .sync_out(ext_sync)
  );

  tpc_sync #(
    .WIDTH(16)
  ) u_lvds_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(lvds_in),
    .sync_out(lvds_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Local trigger coincidence

  tpc_coinc u_coinc (
    .grp_over_thr(grp_over_thr),
    .grp_mask(trig_src_ff[7:0]),
    .coinc_level(trig_src_ff[`TPC_COINC_HI:`TPC_COINC_LO]),
    .local_fire(local_fire),
    .active_count(active_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  // Data value ignored, the write itself is the event
  assign sw_write = reg_wr & hit(reg_addr, `TPC_ADDR_SW_TRIG);

  // Mask changes while running are not blocked; software keeps that rule
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      trig_src_ff <= `TPC_RST_TRIG_SRC;
      trig_out_ff <= `TPC_RST_TRIG_OUT;
      post_cnt_ff <= `TPC_RST_POST_CNT;
      io_data_ff <= `TPC_RST_IO_DATA;
      io_ctrl_ff <= `TPC_RST_IO_CTRL;
      grp_en_ff <= `TPC_RST_GRP_EN;
    end else if (reg_wr) begin
      if (hit(reg_addr, `TPC_ADDR_TRIG_SRC)) begin
        trig_src_ff <= masked(reg_wdata, `TPC_MASK_TRIG_SRC);
      end
      if (hit(reg_addr, `TPC_ADDR_TRIG_OUT)) begin
        trig_out_ff <= masked(reg_wdata, `TPC_MASK_TRIG_OUT);
      end
      if (hit(reg_addr, `TPC_ADDR_POST_CNT)) begin
        post_cnt_ff <= reg_wdata;
      end
      if (hit(reg_addr, `TPC_ADDR_IO_DATA)) begin
        io_data_ff <= reg_wdata[15:0];
      end
      if (hit(reg_addr, `TPC_ADDR_IO_CTRL)) begin
        io_ctrl_ff <= reg_wdata[15:0] & `TPC_MASK_IO_CTRL;
      end
      if (hit(reg_addr, `TPC_ADDR_GRP_EN)) begin
        grp_en_ff <= reg_wdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads

  assign line_level = (lvds_oe_ff & lvds_out_ff) | (~lvds_oe_ff & lvds_sync);

  always @* begin
    nxt_rdata = 32'h00000000;
    case (reg_addr)
      `TPC_ADDR_TRIG_SRC: begin
        nxt_rdata = trig_src_ff;
      end
      `TPC_ADDR_TRIG_OUT: begin
        nxt_rdata = trig_out_ff;
      end
      `TPC_ADDR_POST_CNT: begin
        nxt_rdata = post_cnt_ff;
      end
      `TPC_ADDR_IO_DATA: begin
        nxt_rdata = {16'h0000, line_level};
      end
      `TPC_ADDR_IO_CTRL: begin
        nxt_rdata = {16'h0000, io_ctrl_ff};
      end
      `TPC_ADDR_GRP_EN: begin
        nxt_rdata = {24'h000000, grp_en_ff};
      end
      default: begin
        nxt_rdata = 32'h00000000;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata_ff <= 32'h00000000;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rdata_ff <= reg_rd ? nxt_rdata : 32'h00000000;
      reg_rvalid_ff <= reg_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger sources

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ext_dly_ff <= 1'b0;
    end else begin
      ext_dly_ff <= ext_sync;
    end
  end

  // Edge taken on the synchronised level, so a pulse needs only one clock edge high
  assign ext_rise = ext_sync & ~ext_dly_ff;

  assign sw_trig = sw_write & trig_src_ff[`TPC_BIT_SW_EN] & acq_run;
  assign ext_trig = ext_rise & trig_src_ff[`TPC_BIT_EXT_EN] & acq_run;
  assign loc_trig = local_fire & acq_run;
  assign any_trig = sw_trig | ext_trig | loc_trig;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      acq_trigger_ff <= 1'b0;
    end else begin
      acq_trigger_ff <= any_trig;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Front panel trigger output

  assign fwd_trig = (|(grp_over_thr & trig_out_ff[7:0])) |
                    (ext_rise & trig_out_ff[`TPC_BIT_EXT_EN]) |
                    (sw_write & trig_out_ff[`TPC_BIT_SW_EN]);

  always @* begin
    if (io_ctrl_ff[`TPC_BIT_TEST_MODE]) begin
      nxt_trig_level = io_ctrl_ff[`TPC_BIT_TEST_LEVEL];
    end else begin
      nxt_trig_level = fwd_trig;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      trigger_output_line_ff <= 1'b0;
      trigger_output_oe_ff <= 1'b0;
      clock_output_oe_ff <= 1'b0;
      level_ttl_sel_ff <= 1'b0;
    end else begin
      trigger_output_line_ff <= nxt_trig_level;
      trigger_output_oe_ff <= ~io_ctrl_ff[`TPC_BIT_HIZ];
      clock_output_oe_ff <= ~io_ctrl_ff[`TPC_BIT_HIZ];
      level_ttl_sel_ff <= io_ctrl_ff[`TPC_BIT_TTL];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Differential line direction

  assign io_mode = io_ctrl_ff[`TPC_MODE_HI:`TPC_MODE_LO];

  always @* begin
    nxt_oe = 16'h0000;
    case (io_mode)
      `TPC_MODE_GPIO: begin
        nxt_oe = {{4{io_ctrl_ff[5]}}, {4{io_ctrl_ff[4]}},
                  {4{io_ctrl_ff[3]}}, {4{io_ctrl_ff[2]}}};
      end
      `TPC_MODE_PROG: begin
        nxt_oe = 16'hFFFF;
      end
      `TPC_MODE_PATTERN: begin
        nxt_oe = 16'h0000;
      end
      default: begin
        nxt_oe = 16'h0000;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      lvds_out_ff <= 16'h0000;
      lvds_oe_ff <= 16'h0000;
    end else begin
      lvds_out_ff <= io_data_ff;
      lvds_oe_ff <= nxt_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Post trigger window

  // One sample per clock; the fixed delay never changes at run time
  assign post_total = {1'b0, post_cnt_ff} + `TPC_FIXED_TRIG_DELAY;

  // A new trigger restarts the window
  always @* begin
    nxt_post_left = post_left_ff;
    nxt_post_active = post_active_ff;
    nxt_post_done = 1'b0;
    if (acq_trigger_ff) begin
      nxt_post_left = post_total;
      nxt_post_active = (post_total != 33'h00000000);
      nxt_post_done = (post_total == 33'h00000000);
    end else if (post_left_ff != 33'h00000000) begin
      nxt_post_left = post_left_ff - 33'h00000001;
      if (post_left_ff == 33'h00000001) begin
        nxt_post_active = 1'b0;
        nxt_post_done = 1'b1;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      post_left_ff <= 33'h00000000;
      post_active_ff <= 1'b0;
      post_done_ff <= 1'b0;
      post_count_setting_ff <= 32'h00000000;
    end else begin
      post_left_ff <= nxt_post_left;
      post_active_ff <= nxt_post_active;
      post_done_ff <= nxt_post_done;
      post_count_setting_ff <= post_cnt_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pattern capture and group storage

  // Internal trigger is the end of the post trigger window
  assign delayed_trig = nxt_post_done;
  assign capture_now = io_ctrl_ff[`TPC_BIT_LATCH_EXT] ?
                       ext_rise : delayed_trig;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pattern_ff <= 16'h0000;
      pattern_stb_ff <= 1'b0;
      store_group_ff <= 8'h00;
    end else begin
      if (capture_now) begin
        pattern_ff <= lvds_sync;
      end
      pattern_stb_ff <= capture_now;
      store_group_ff <= acq_run ? grp_en_ff : 8'h00;
    end
  end

endmodule // tpc_top

//--- verification/tb_top.sv
// Directed testbench of the trigger and panel register block
`timescale 1ns/10ps
`include "tpc_defs.vh"
module tb_top;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg [15:0] reg_addr = 16'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [31:0] reg_wdata = 32'h0;
  reg acq_run = 1'b0;
  reg [7:0] grp_over_thr = 8'h00;
  reg [15:0] panel_val = 16'hA5C3;
  wire [31:0] reg_rdata_ff, post_count_setting_ff;
  wire reg_rvalid_ff, trigger_output_line_ff, trigger_output_oe_ff;
  wire clock_output_oe_ff, level_ttl_sel_ff, acq_trigger_ff, ext_pin;
  wire post_active_ff, post_done_ff, pattern_stb_ff;
  wire [15:0] lvds_in, lvds_out_ff, lvds_oe_ff, pattern_ff;
  wire [7:0] store_group_ff;
  reg seen_trg, seen_out;
  integer failures = 0;
  integer n_compared = 0;
  integer i;
  localparam [79:0] ADRS = {16'h810C, 16'h8110, 16'h8114, 16'h811C,
    16'h8120};
  localparam [159:0] MSKS = {32'hC70000FF, 32'hC00000FF, 32'hFFFFFFFF,
    32'h0000C2FF, 32'h000000FF};
  always #20 clk_sys = ~clk_sys;
  tpc_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
    .acq_run(acq_run), .grp_over_thr(grp_over_thr),
    .external_trigger_input(ext_pin),
    .trigger_output_line_ff(trigger_output_line_ff),
    .trigger_output_oe_ff(trigger_output_oe_ff),
    .clock_output_oe_ff(clock_output_oe_ff),
    .level_ttl_sel_ff(level_ttl_sel_ff), .lvds_in(lvds_in),
    .lvds_out_ff(lvds_out_ff), .lvds_oe_ff(lvds_oe_ff),
    .acq_trigger_ff(acq_trigger_ff), .post_active_ff(post_active_ff),
    .post_done_ff(post_done_ff),
    .post_count_setting_ff(post_count_setting_ff),
    .store_group_ff(store_group_ff), .pattern_ff(pattern_ff),
    .pattern_stb_ff(pattern_stb_ff));
  tpc_panel_model u_panel (.clk_sys(clk_sys), .lvds_out_ff(lvds_out_ff),
    .lvds_oe_ff(lvds_oe_ff), .panel_val(panel_val),
    .external_trigger_input(ext_pin), .lvds_in(lvds_in));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [15:0] a, input [31:0] d);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
    end
  endtask
  task rdc(input [15:0] a, input [31:0] e);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rvalid_ff, 1'b1);
      chk(reg_rdata_ff, e);
    end
  endtask
  // Trigger pulse must last exactly one cycle
  task sw(input [31:0] d, input e_acq, input e_out);
    begin
      wr(`TPC_ADDR_SW_TRIG, d);
      chk({acq_trigger_ff, trigger_output_line_ff}, {e_acq, e_out});
      @(posedge clk_sys);
      #1;
      chk(acq_trigger_ff, 1'b0);
    end
  endtask
  // Counts cycles from the first post window cycle to its end
  task win(input [31:0] e);
    integer n;
    begin
      n = 0;
      while (post_done_ff !== 1'b1 && n < 100) begin
        @(posedge clk_sys);
        #1;
        n = n + 1;
      end
      chk(n, e);
    end
  endtask
  task ext_watch;
    begin
      seen_trg = 1'b0;
      seen_out = 1'b0;
      fork
        u_panel.pulse_ext;
        repeat (7) begin
          @(posedge clk_sys);
          #1;
          seen_trg = seen_trg | acq_trigger_ff;
          seen_out = seen_out | trigger_output_line_ff;
        end
      join
    end
  endtask
  task grp(input [7:0] v, input e_acq, input e_out);
    begin
      @(posedge clk_sys) grp_over_thr <= v;
      @(posedge clk_sys);
      #1;
      chk({acq_trigger_ff, trigger_output_line_ff}, {e_acq, e_out});
    end
  endtask
  task pin(input [15:0] c, input [15:0] e_oe, input [2:0] e_drv);
    begin
      wr(`TPC_ADDR_IO_CTRL, {16'h0, c});
      @(posedge clk_sys);
      #1;
      chk(lvds_oe_ff, e_oe);
      chk({trigger_output_oe_ff, clock_output_oe_ff, level_ttl_sel_ff},
        e_drv);
    end
  endtask
  task finish_test;
    begin
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // Whole run takes well under a thousand cycles
  initial begin
    #400000;
    failures = failures + 1;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (i = 0; i < 5; i = i + 1) begin
      rdc(ADRS[16*i +: 16], 32'h0);
      wr(ADRS[16*i +: 16], 32'hFFFFFFFF);
      rdc(ADRS[16*i +: 16], MSKS[32*i +: 32]);
      wr(ADRS[16*i +: 16], 32'h0);
    end
    rdc(`TPC_ADDR_SW_TRIG, 32'h0);
    rdc(16'h8124, 32'h0);
    @(posedge clk_sys) acq_run <= 1'b1;
    sw(32'h0, 1'b0, 1'b0);
    wr(`TPC_ADDR_TRIG_SRC, 32'h80000000);
    wr(`TPC_ADDR_TRIG_OUT, 32'h80000000);
    wr(`TPC_ADDR_POST_CNT, 32'h5);
    sw(32'h0, 1'b1, 1'b1);
    win(32'd15);
    chk(post_active_ff, 1'b0);
    chk(post_count_setting_ff, 32'h5);
    chk({pattern_stb_ff, pattern_ff}, {1'b1, 16'hA5C3});
    sw(32'hFFFFFFFF, 1'b1, 1'b1);
    @(posedge clk_sys) acq_run <= 1'b0;
    sw(32'h0, 1'b0, 1'b1);
    @(posedge clk_sys) acq_run <= 1'b1;
    wr(`TPC_ADDR_TRIG_SRC, 32'h0);
    ext_watch;
    chk(seen_trg, 1'b0);
    wr(`TPC_ADDR_TRIG_SRC, 32'h40000000);
    wr(`TPC_ADDR_TRIG_OUT, 32'h40000000);
    wr(`TPC_ADDR_IO_CTRL, 32'h0200);
    @(posedge clk_sys) panel_val <= 16'h3C96;
    ext_watch;
    chk({seen_trg, seen_out}, 2'b11);
    chk(pattern_ff, 16'h3C96);
    wr(`TPC_ADDR_TRIG_SRC, 32'h0100000F);
    wr(`TPC_ADDR_TRIG_OUT, 32'h00000001);
    grp(8'h01, 1'b0, 1'b1);
    grp(8'h03, 1'b1, 1'b1);
    grp(8'hF0, 1'b0, 1'b0);
    grp(8'h00, 1'b0, 1'b0);
    pin(16'hC000, 16'h0000, 3'b110);
    chk(trigger_output_line_ff, 1'b1);
    pin(16'h8000, 16'h0000, 3'b110);
    chk(trigger_output_line_ff, 1'b0);
    pin(16'h0014, 16'h0F0F, 3'b110);
    pin(16'h0043, 16'hFFFF, 3'b001);
    pin(16'h00BC, 16'h0000, 3'b110);
    pin(16'h0040, 16'hFFFF, 3'b110);
    wr(`TPC_ADDR_IO_DATA, 32'h1234);
    rdc(`TPC_ADDR_IO_DATA, 32'h1234);
    chk(lvds_out_ff, 16'h1234);
    pin(16'h0080, 16'h0000, 3'b110);
    repeat (3) @(posedge clk_sys);
    rdc(`TPC_ADDR_IO_DATA, 32'h3C96);
    @(posedge clk_sys) acq_run <= 1'b0;
    wr(`TPC_ADDR_GRP_EN, 32'h5A);
    chk(store_group_ff, 8'h00);
    @(posedge clk_sys) acq_run <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk(store_group_ff, 8'h5A);
    finish_test;
  end
endmodule // tb_top

//--- verification/tpc_panel_model.sv
// Front panel model: trigger input pin and differential lines
`timescale 1ns/10ps
module tpc_panel_model (
  // Clock
  input wire clk_sys,
  // Device side of the lines
  input wire [15:0] lvds_out_ff,
  input wire [15:0] lvds_oe_ff,
  // Levels the panel puts on lines it drives
  input wire [15:0] panel_val,
  // Pin levels seen by the device
  output reg external_trigger_input,
  output wire [15:0] lvds_in
);
  // A line driven by the device shows its value, others the panel's
  assign lvds_in = (lvds_out_ff & lvds_oe_ff) | (panel_val & ~lvds_oe_ff);
  initial external_trigger_input = 1'b0;
  // Three cycles each way so the two-stage synchroniser always sees it
  task pulse_ext;
    begin
      @(posedge clk_sys);
      external_trigger_input <= 1'b1;
      repeat (3) @(posedge clk_sys);
      external_trigger_input <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask
endmodule // tpc_panel_model

//--- verification/tpc_top_asserts.sv
// Port checker of the trigger and panel block
`timescale 1ns/10ps
`include "tpc_defs.vh"
module tpc_chk (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Register port
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  input wire reg_rvalid_ff,
  // Trigger and panel
  input wire acq_run,
  input wire [7:0] grp_over_thr,
  input wire trigger_output_line_ff,
  input wire trigger_output_oe_ff,
  input wire clock_output_oe_ff,
  input wire level_ttl_sel_ff,
  input wire [15:0] lvds_oe_ff,
  input wire acq_trigger_ff,
  input wire post_active_ff,
  input wire post_done_ff,
  input wire [31:0] post_count_setting_ff,
  input wire [7:0] store_group_ff
);
  reg [31:0] src_ff, cnt_ff;
  reg [15:0] ctl_ff;
  reg [7:0] grp_ff;
  wire [15:0] exp_oe;
  wire loc;
  wire sw_wr;
  // Shadow copies of the trigger source, panel control and group enable registers, taken from the write strobes, and a count of post window cycles
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      src_ff <= 32'h0;
      ctl_ff <= 16'h0;
      grp_ff <= 8'h0;
      cnt_ff <= 32'h0;
    end else begin
      if (reg_wr && reg_addr == `TPC_ADDR_TRIG_SRC)
        src_ff <= reg_wdata & `TPC_MASK_TRIG_SRC;
      if (reg_wr && reg_addr == `TPC_ADDR_IO_CTRL)
        ctl_ff <= reg_wdata[15:0] & `TPC_MASK_IO_CTRL;
      if (reg_wr && reg_addr == `TPC_ADDR_GRP_EN)
        grp_ff <= reg_wdata[7:0];
      if (acq_trigger_ff)
        cnt_ff <= 32'h0;
      else if (post_active_ff)
        cnt_ff <= cnt_ff + 32'h1;
    end
  end
  assign exp_oe = ctl_ff[7:6] == 2'h0 ? {{4{ctl_ff[5]}}, {4{ctl_ff[4]}},
    {4{ctl_ff[3]}}, {4{ctl_ff[2]}}} : ctl_ff[7:6] == 2'h1 ? 16'hFFFF : 16'h0;
  assign loc = acq_run &&
    $countones(grp_over_thr & src_ff[7:0]) > src_ff[26:24];
  assign sw_wr = reg_wr && reg_addr == `TPC_ADDR_SW_TRIG;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  property p_rd; reg_rd |=> reg_rvalid_ff; endproperty
  a_rd: assert property (p_rd)
    else $error("read not answered");
  property p_sw; sw_wr && src_ff[31] && acq_run |=> acq_trigger_ff; endproperty
  a_sw: assert property (p_sw)
    else $error("software trigger lost");
  property p_stop; !acq_run |=> !acq_trigger_ff; endproperty
  a_stop: assert property (p_stop)
    else $error("trigger while stopped");
  property p_loc; loc |=> acq_trigger_ff; endproperty
  a_loc: assert property (p_loc)
    else $error("local trigger lost");
  property p_win; acq_trigger_ff |=> post_active_ff [*8]; endproperty
  a_win: assert property (p_win)
    else $error("post window short");
  property p_cnt; post_done_ff |-> {1'b0, cnt_ff} ==
    {1'b0, post_count_setting_ff} + `TPC_FIXED_TRIG_DELAY; endproperty
  a_cnt: assert property (p_cnt)
    else $error("post window length");
  property p_tst; $past(rst_n) && ctl_ff[15] && $stable(ctl_ff) |->
    trigger_output_line_ff == ctl_ff[14]; endproperty
  a_tst: assert property (p_tst)
    else $error("static trigger level");
  property p_pins; $past(rst_n) && $stable(ctl_ff) |->
    trigger_output_oe_ff == !ctl_ff[1] && clock_output_oe_ff == !ctl_ff[1]
    && level_ttl_sel_ff == ctl_ff[0] && lvds_oe_ff == exp_oe; endproperty
  a_pins: assert property (p_pins)
    else $error("pin control");
  property p_store; $past(rst_n) |-> store_group_ff ==
    ($past(acq_run) ? $past(grp_ff) : 8'h00); endproperty
  a_store: assert property (p_store)
    else $error("store groups");
  c_sw: cover property (sw_wr && acq_run);
  c_done: cover property (post_done_ff);
  c_loc: cover property (loc && src_ff[26:24] != 3'h0);
endmodule // tpc_chk
bind tpc_top tpc_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rvalid_ff(reg_rvalid_ff),
  .acq_run(acq_run), .grp_over_thr(grp_over_thr),
  .trigger_output_line_ff(trigger_output_line_ff),
  .trigger_output_oe_ff(trigger_output_oe_ff),
  .clock_output_oe_ff(clock_output_oe_ff),
  .level_ttl_sel_ff(level_ttl_sel_ff), .lvds_oe_ff(lvds_oe_ff),
  .acq_trigger_ff(acq_trigger_ff), .post_active_ff(post_active_ff),
  .post_done_ff(post_done_ff),
  .post_count_setting_ff(post_count_setting_ff),
  .store_group_ff(store_group_ff));
